// file: logic/prox_cfg_top.sv
// Purpose: I2C register access and proximity modulator timing for the light sensor
// Assumes: SCL and SDA arrive asynchronously; measurement requests come from same-clock logic
// Notes:   SDA is open drain; SDA_OE high pulls the line low
`timescale 1ns/1ns
module prox_cfg_top
  import prox_cfg_pkg::*;
#(
  parameter logic [6:0] TARGET_ADDR = TARGET_ADDR_DEFAULT
) (
  // Clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       ARST_N,
  // I2C pins
  input  wire logic       SCL_IN,
  input  wire logic       SDA_IN,
  output logic            SDA_OUT,
  output logic            SDA_OE,
  // Measurement control
  input  wire logic       PROX_REQ,
  input  wire logic       AMB_REQ,
  input  wire logic [7:0] LED_CURRENT,
  // Modulator outputs
  output logic            STANDBY,
  output logic            EMITTER_DRIVE,
  output logic [7:0]      EMITTER_CURRENT,
  output logic            EVAL_ENABLE,
  output logic            EVAL_PHASE
);

  typedef struct packed {
    bus_state_e st;
    logic       scl_s1;
    logic       scl_s2;
    logic       scl_p;
    logic       sda_s1;
    logic       sda_s2;
    logic       sda_p;
    logic [3:0] bits;
    logic [7:0] sh;
    logic       rw;
    logic       first;
    logic       nack;
    logic [7:0] ptr;
    logic [1:0] freq;
    logic [2:0] dly;
    logic [2:0] dead;
    logic       oe;
    logic       sda_o;
    logic [8:0] phase;
    logic       drive;
    logic       eval_en;
    logic       eval_pol;
    logic [7:0] cur;
    logic       standby;
  } state_s;

  localparam state_s STATE_RESET = '{
    st: S_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, scl_p: 1'b1,
    sda_s1: 1'b1, sda_s2: 1'b1, sda_p: 1'b1,
    bits: 4'h0, sh: 8'h00, rw: 1'b0, first: 1'b0, nack: 1'b0, ptr: 8'h00,
    freq: FREQ_RESET, dly: DELAY_RESET, dead: DEAD_RESET,
    oe: 1'b0, sda_o: 1'b0, phase: 9'h000, drive: 1'b0,
    eval_en: 1'b0, eval_pol: 1'b0, cur: 8'h00, standby: 1'b1};

  state_s s_q;
  state_s s_d;

  // Read view of a register; unused bits and unmapped addresses give zero
  function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [1:0] f,
                                          input logic [2:0] d, input logic [2:0] t);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      ADDR_FREQ:   v = {6'h00, f};                         // see R15
      ADDR_TIMING: v = {d, 2'h0, t};                       // see R15
      default:     v = 8'h00;                              // see R08
    endcase
    return v;
  endfunction

  logic       scl_rise;
  logic       scl_fall;
  logic       start_c;
  logic       stop_c;
  logic [8:0] half;
  logic [8:0] period;
  logic [8:0] ep;
  logic       prox_on;
  logic [7:0] rd;

  always_comb begin
    s_d = s_q;
    s_d.scl_s1 = SCL_IN;
    s_d.scl_s2 = s_q.scl_s1;
    s_d.scl_p  = s_q.scl_s2;
    s_d.sda_s1 = SDA_IN;
    s_d.sda_s2 = s_q.sda_s1;
    s_d.sda_p  = s_q.sda_s2;
    scl_rise = s_q.scl_s2 & ~s_q.scl_p;
    scl_fall = ~s_q.scl_s2 & s_q.scl_p;
    start_c  = s_q.scl_s2 & s_q.scl_p & s_q.sda_p & ~s_q.sda_s2;
    stop_c   = s_q.scl_s2 & s_q.scl_p & ~s_q.sda_p & s_q.sda_s2;
    rd       = reg_read(s_q.ptr, s_q.freq, s_q.dly, s_q.dead);

    // Bus target; a start in any state restarts, so stop or repeated start both work
    if (start_c) begin                                     // see R13
      s_d.st   = S_ADDR;
      s_d.bits = 4'h0;
      s_d.oe   = 1'b0;
    end else if (stop_c) begin
      s_d.st = S_IDLE;
      s_d.oe = 1'b0;
    end else begin
      case (s_q.st)
        S_IDLE: begin
          s_d.oe = 1'b0;
        end
        S_ADDR, S_WR: begin
          if (scl_rise && s_q.bits != 4'h8) begin
            s_d.sh   = {s_q.sh[6:0], s_q.sda_s2};
            s_d.bits = s_q.bits + 4'h1;
          end else if (scl_fall && s_q.bits == 4'h8) begin
            if (s_q.st == S_ADDR) begin
              if (s_q.sh[7:1] == TARGET_ADDR) begin
                s_d.st    = S_ADDR_AK;
                s_d.rw    = s_q.sh[0];
                s_d.first = 1'b1;
                s_d.oe    = 1'b1;
              end else begin
                s_d.st = S_IDLE;
              end
            end else begin
              if (s_q.first) begin
                s_d.ptr = s_q.sh;                          // see R11
              end else begin
                if (s_q.ptr == ADDR_FREQ) begin
                  s_d.freq = s_q.sh[FREQ_LSB +: 2];         // see R01
                end
                if (s_q.ptr == ADDR_TIMING) begin
                  s_d.dly  = s_q.sh[DELAY_LSB +: 3];        // see R04
                  s_d.dead = s_q.sh[DEAD_LSB +: 3];         // see R05
                end
                s_d.ptr = s_q.ptr + 8'h01;
              end
              s_d.first = 1'b0;
              s_d.st    = S_WR_AK;
              s_d.oe    = 1'b1;
            end
          end
        end
        S_ADDR_AK: begin
          if (scl_fall) begin
            s_d.bits = 4'h0;
            if (s_q.rw) begin
              s_d.sh = rd;                                 // see R12
              s_d.oe = ~rd[7];
              s_d.st = S_RD;
            end else begin
              s_d.oe = 1'b0;
              s_d.st = S_WR;
            end
          end
        end
        S_WR_AK: begin
          if (scl_fall) begin
            s_d.oe   = 1'b0;
            s_d.bits = 4'h0;
            s_d.st   = S_WR;
          end
        end
        S_RD: begin
          if (scl_fall) begin
            s_d.bits = s_q.bits + 4'h1;
            s_d.sh   = {s_q.sh[6:0], 1'b0};
            if (s_q.bits == 4'h7) begin
              s_d.oe = 1'b0;
              s_d.st = S_RD_AK;
            end else begin
              s_d.oe = ~s_q.sh[6];
            end
          end
        end
        S_RD_AK: begin
          if (scl_rise) begin
            s_d.nack = s_q.sda_s2;
            s_d.ptr  = s_q.ptr + 8'h01;                     // see R14
          end else if (scl_fall) begin
            if (s_q.nack) begin
              s_d.st = S_IDLE;
            end else begin
              s_d.sh   = rd;                               // see R12
              s_d.oe   = ~rd[7];
              s_d.bits = 4'h0;
              s_d.st   = S_RD;
            end
          end
        end
        default: begin
          s_d.st = S_IDLE;
          s_d.oe = 1'b0;
        end
      endcase
    end

    // Modulator; period doubles per frequency code step
    half    = HALF_FAST << s_q.freq;                        // see R01
    period  = half << 1;
    prox_on = PROX_REQ;
    s_d.standby = ~(PROX_REQ | AMB_REQ);                    // see R09
    // Current sink follows the proximity request only, so standby forces it off
    s_d.cur = prox_on ? LED_CURRENT : 8'h00;                // see R10
    if (!prox_on) begin
      s_d.phase = 9'h000;
    end else if (s_q.phase == period - 9'h001) begin
      s_d.phase = 9'h000;
    end else begin
      s_d.phase = s_q.phase + 9'h001;
    end
    s_d.drive = prox_on & (s_q.phase < half);               // see R03
    // Evaluation phase runs a fixed number of ticks behind the drive
    if (s_q.phase >= {6'h00, s_q.dly}) begin
      ep = s_q.phase - {6'h00, s_q.dly};                    // see R04
    end else begin
      ep = s_q.phase + period - {6'h00, s_q.dly};
    end
    s_d.eval_pol = prox_on & (ep < half);
    // Blanking next to both edges trades amplitude for disturbance rejection
    s_d.eval_en = prox_on & ~(ep < {6'h00, s_q.dead})
                  & ~(ep >= half && ep < half + {6'h00, s_q.dead}); // see R05 see R06
    s_d.sda_o = 1'b0;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= STATE_RESET;                                   // see R02
    end else begin
      s_q <= s_d;
    end
  end

  assign SDA_OUT         = s_q.sda_o;
  assign SDA_OE          = s_q.oe;
  assign STANDBY         = s_q.standby;
  assign EMITTER_DRIVE   = s_q.drive;
  assign EMITTER_CURRENT = s_q.cur;
  assign EVAL_ENABLE     = s_q.eval_en;
  assign EVAL_PHASE      = s_q.eval_pol;

endmodule // prox_cfg_top

// file: logic/prox_cfg_pkg.sv
// Purpose: Constants for the proximity modulator configuration and register read block
// Assumes: 100 MHz system clock, I2C target with 7-bit address
// Notes:   One modulator tick is one system clock; delay and dead time steps are ticks
// How it works
// R01: Frequency field bits 1:0 picks 3.125 MHz, 1.5625 MHz, 781.25 kHz, 390.625 kHz.
// R02: Frequency field resets to the 781.25 kHz code.
// R03: Proximity emitter drive is a square wave at the selected frequency.
// R04: Evaluation lags the emitter drive by the delay field, bits 7:5.
// R05: Evaluation is blanked around each edge for the dead-time field, bits 2:0.
// R06: Larger dead time shortens the evaluated window, lowering signal amplitude.
// R07: Host should program the timing register with 129: delay 4, dead 1.
// R08: Host must not use the reserved ambient IR level register at 8Bh.
// R09: With no measurement requested the block idles in standby, I2C still active.
// R10: In standby the emitter current sink stays off whatever current is programmed.
// R11: Host reads by first writing only the register address byte.
// R12: A read returns the register most recently addressed.
// R13: Stop or repeated start between address write and read both work.
// R14: Register pointer advances by one after each byte read.
// R15: Unused bits ignore writes and read as zero.
package prox_cfg_pkg;

  localparam logic [7:0] ADDR_FREQ      = 8'h89;
  localparam logic [7:0] ADDR_TIMING    = 8'h8A;
  localparam logic [7:0] ADDR_AMBIENT_IR = 8'h8B;

  localparam int unsigned FREQ_LSB   = 0;
  localparam int unsigned DELAY_LSB  = 5;
  localparam int unsigned DEAD_LSB   = 0;

  localparam logic [1:0] FREQ_RESET   = 2'h2;
  localparam logic [2:0] DELAY_RESET  = 3'h0;
  localparam logic [2:0] DEAD_RESET   = 3'h0;

  // Half period of the fastest square wave: 100 MHz / 3.125 MHz / 2
  localparam int unsigned CLK_HZ       = 100_000_000;
  localparam int unsigned FAST_FREQ_HZ = 3_125_000;
  localparam logic [8:0]  HALF_FAST    = 9'(CLK_HZ / FAST_FREQ_HZ / 2);

  // Bus address value is arbitrary; override through the top parameter
  localparam logic [6:0] TARGET_ADDR_DEFAULT = 7'h13;

  typedef enum logic [6:0] {
    S_IDLE    = 7'b000_0001,
    S_ADDR    = 7'b000_0010,
    S_ADDR_AK = 7'b000_0100,
    S_WR      = 7'b000_1000,
    S_WR_AK   = 7'b001_0000,
    S_RD      = 7'b010_0000,
    S_RD_AK   = 7'b100_0000
  } bus_state_e;

endpackage

// file: dv/prox_cfg_monitor.sv
// Purpose: Port-level checks of standby, emitter drive and SDA timing
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   High-run length of the drive is counted in helper logic
`timescale 1ns/1ns
module prox_cfg_monitor (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       ARST_N,
  // I2C pins
  input wire logic       SCL_IN,
  input wire logic       SDA_OE,
  // Modulator
  input wire logic       PROX_REQ,
  input wire logic       AMB_REQ,
  input wire logic [7:0] LED_CURRENT,
  input wire logic       STANDBY,
  input wire logic       EMITTER_DRIVE,
  input wire logic [7:0] EMITTER_CURRENT,
  input wire logic       EVAL_ENABLE,
  input wire logic       EVAL_PHASE
);
  logic [7:0] hi_q;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N)
      hi_q <= 8'h00;
    else
      hi_q <= EMITTER_DRIVE ? hi_q + 8'h01 : 8'h00;
  end
  property p_sby_on; !PROX_REQ && !AMB_REQ |=> STANDBY; endproperty
  a_sby_on: assert property (p_sby_on) else $error("no standby");
  property p_sby_off; PROX_REQ || AMB_REQ |=> !STANDBY; endproperty
  a_sby_off: assert property (p_sby_off) else $error("standby kept");
  property p_sink_off; STANDBY |-> EMITTER_CURRENT == 8'h00; endproperty
  a_sink_off: assert property (p_sink_off) else $error("sink on in standby");
  property p_cur; PROX_REQ |=> EMITTER_CURRENT == $past(LED_CURRENT); endproperty
  a_cur: assert property (p_cur) else $error("current mismatch");
  property p_drv_off; !PROX_REQ |=> !EMITTER_DRIVE && EMITTER_CURRENT == 8'h00; endproperty
  a_drv_off: assert property (p_drv_off) else $error("drive while idle");
  property p_eval_off; !PROX_REQ |=> !EVAL_ENABLE && !EVAL_PHASE; endproperty
  a_eval_off: assert property (p_eval_off) else $error("eval while idle");
  // Natural falls only; a drop caused by the request going low is excluded
  property p_half;
    $fell(EMITTER_DRIVE) && $past(PROX_REQ) |-> hi_q inside {8'h10, 8'h20, 8'h40, 8'h80};
  endproperty
  a_half: assert property (p_half) else $error("bad half period");
  property p_oe; $changed(SDA_OE) |-> !$past(SCL_IN, 3); endproperty
  a_oe: assert property (p_oe) else $error("SDA moved with SCL high");
endmodule // prox_cfg_monitor
bind prox_cfg_top prox_cfg_monitor u_prox_cfg_monitor (
  .CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .SCL_IN(SCL_IN), .SDA_OE(SDA_OE),
  .PROX_REQ(PROX_REQ), .AMB_REQ(AMB_REQ), .LED_CURRENT(LED_CURRENT),
  .STANDBY(STANDBY), .EMITTER_DRIVE(EMITTER_DRIVE), .EMITTER_CURRENT(EMITTER_CURRENT),
  .EVAL_ENABLE(EVAL_ENABLE), .EVAL_PHASE(EVAL_PHASE));

// file: dv/i2c_host_model.sv
// Purpose: I2C bus master model for the target pins
// Assumes: SDA wire is resolved outside with a pull-up
// Notes:   SCL low 12 clocks, high 6; SDA moves mid-low to keep hold time
`timescale 1ns/1ns
module i2c_host_model (
  // Clock
  input wire logic clk,
  // Bus
  input wire logic sda,
  output logic     scl,
  output logic     sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic hold();
    repeat (6) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    hold();
    sda_low = !b;
    hold();
    scl = 1'b1;
    hold();
    r = sda;
  endtask
  // Serves as repeated start as well as first start
  task automatic start();
    logic r;
    bit_io(1'b1, r);
    sda_low = 1'b1;
    hold();
  endtask
  task automatic stop();
    logic r;
    bit_io(1'b0, r);
    sda_low = 1'b0;
    hold();
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // i2c_host_model

// file: dv/tb_top.sv
// Purpose: Register and modulator tests through the I2C pins
// Assumes: Target sits at its default address
// Notes:   Expected counts come from frequency code and timing fields
`timescale 1ns/1ns
module tb_top;
  import prox_cfg_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n;
  logic       prox_req = 1'b0;
  logic       amb_req = 1'b0;
  logic [7:0] led_cur = 8'h5A;
  logic       scl, host_low, sda_oe, sda_out, standby, drive, eval_en, eval_ph;
  logic [7:0] cur;
  int         n_errors = 0;
  int         compares = 0;
  // Open drain: an enabled target shows its data value, so a stuck data bit corrupts reads
  wire        sda = !(host_low || (sda_oe && !sda_out));
  wire  [3:0] mon = {eval_en, eval_ph, !drive, drive};
  always #5 clk = !clk;
  prox_cfg_top u_prox_cfg_top (
    .CLK_SYS(clk), .ARST_N(arst_n), .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out),
    .SDA_OE(sda_oe), .PROX_REQ(prox_req), .AMB_REQ(amb_req), .LED_CURRENT(led_cur),
    .STANDBY(standby), .EMITTER_DRIVE(drive), .EMITTER_CURRENT(cur),
    .EVAL_ENABLE(eval_en), .EVAL_PHASE(eval_ph));
  i2c_host_model u_i2c_host_model (.clk(clk), .sda(sda), .scl(scl), .sda_low(host_low));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %0h want %0h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic addr(input logic [7:0] a);
    logic ack;
    u_i2c_host_model.start();
    u_i2c_host_model.put({TARGET_ADDR_DEFAULT, 1'b0}, ack);
    chk(ack, 1'b1);
    u_i2c_host_model.put(a, ack);
    chk(ack, 1'b1);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    logic ack;
    addr(a);
    u_i2c_host_model.put(d, ack);
    chk(ack, 1'b1);
    u_i2c_host_model.stop();
  endtask
  // Two bytes back to back, the second one NACKed
  task automatic reg_rd(input logic [7:0] a, input logic sr, input logic [15:0] exp);
    logic ack;
    logic [7:0] b0, b1;
    addr(a);
    if (!sr) u_i2c_host_model.stop();
    u_i2c_host_model.start();
    u_i2c_host_model.put({TARGET_ADDR_DEFAULT, 1'b1}, ack);
    chk(ack, 1'b1);
    u_i2c_host_model.get(1'b0, b0);
    u_i2c_host_model.get(1'b1, b1);
    u_i2c_host_model.stop();
    chk({b0, b1}, exp);
  endtask
  task automatic cnt(input int k, output int n);
    n = 0;
    while (mon[k] !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (n == 300) begin
      n_errors++;
      tally_and_finish();
    end
  endtask
  // Delay, dead time and the rest of the half period add up to the half period
  task automatic burst(input int half, input int dly, input int dead);
    int n, m, k;
    prox_req = 1'b1;
    cnt(0, n);
    cnt(2, n);
    chk(n, dly);
    cnt(3, m);
    chk(m, dead);
    cnt(1, k);
    chk(n + m + k, half);
    chk({standby, cur}, {1'b0, led_cur});
    prox_req = 1'b0;
    repeat (2) @(negedge clk);
    chk({standby, drive, eval_en, eval_ph, cur}, 12'h800);
  endtask
  initial begin
    logic ack;
    arst_n = 1'b0;
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    reg_rd(ADDR_FREQ, 1'b0, 16'h0200);
    burst(64, 0, 0);
    for (int f = 0; f < 4; f++) begin
      reg_wr(ADDR_FREQ, 8'hFC | 8'(f));
      reg_rd(ADDR_FREQ, f[0], {8'(f), 8'h00});
      burst(16 << f, 0, 0);
    end
    reg_wr(ADDR_TIMING, 8'h81);
    reg_rd(ADDR_FREQ, 1'b1, 16'h0381);
    burst(128, 4, 1);
    reg_wr(ADDR_TIMING, 8'hFF);
    reg_rd(ADDR_FREQ, 1'b0, 16'h03E7);
    burst(128, 7, 7);
    // Unmapped pair reads zero; the reserved level register is never touched
    reg_rd(8'h90, 1'b0, 16'h0000);
    u_i2c_host_model.start();
    u_i2c_host_model.put({TARGET_ADDR_DEFAULT ^ 7'h01, 1'b0}, ack);
    chk(ack, 1'b0);
    u_i2c_host_model.stop();
    arst_n = 1'b0;
    @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    reg_rd(ADDR_FREQ, 1'b1, 16'h0200);
    amb_req = 1'b1;
    repeat (2) @(negedge clk);
    chk({standby, cur}, 9'h000);
    amb_req = 1'b0;
    tally_and_finish();
  end
endmodule // tb_top
